// ==== logic/wake_pkg.sv ====
// shared constants and types for the halt wake-up, periodic timer and reset
package wake_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 4;
  localparam int VEC_W = 12;
  localparam int CNT_W = 14;
  localparam int SETTLE_W = 7;

  localparam logic [7:0] ADDR_SPEAKER_WAKE = 8'h12;
  localparam logic [7:0] ADDR_TIMER_CTRL = 8'h16;
  localparam logic [7:0] ADDR_WAKE_EN_A = 8'h18;
  localparam logic [7:0] ADDR_WAKE_EN_B = 8'h19;
  localparam logic [7:0] ADDR_WAKE_EN_D = 8'h1A;
  localparam logic [7:0] ADDR_WAKE_EN_E = 8'h1B;
  localparam logic [7:0] ADDR_OPTIONS = 8'h1C;
  localparam logic [7:0] ADDR_CLEAR_KEY = 8'h1D;
  localparam logic [7:0] ADDR_HALT_STATUS = 8'h1F;

  // speaker_wake_control fields
  localparam int SPK_EN_BIT = 0;
  localparam int SPK_SEL_LO = 1;
  localparam int SPK_SEL_HI = 2;
  localparam int SPK_FLAG_BIT = 3;
  // periodic_timer_control fields
  localparam int TMR_SEL_LO = 0;
  localparam int TMR_SEL_HI = 1;
  localparam int TMR_EN_BIT = 2;
  localparam int TMR_FLAG_BIT = 3;
  // option register fields
  localparam int OPT_DOUBLE_EDGE_BIT = 0;
  localparam int OPT_CARRIER_BIT = 1;
  localparam int OPT_RESET_PC_BIT = 2;

  localparam logic [3:0] REG_RESET = 4'h0;
  localparam logic [3:0] CLEAR_KEY_VALUE = 4'hA;
  localparam logic [11:0] WAKE_VECTOR = 12'h004;
  localparam logic [11:0] RESET_VECTOR = 12'h000;
  localparam int STABLE_CYCLES = 64;

  // the low-rate oscillator paces the timer; clk only samples it
  localparam int CLK_PERIOD_NS = 100;
  localparam int LRC_FREQ_KHZ = 100;
  localparam int PERIOD_MS_SEL0 = 1;
  localparam int PERIOD_MS_SEL1 = 16;
  localparam int PERIOD_MS_SEL2 = 64;
  localparam int PERIOD_MS_SEL3 = 128;
  localparam int TICKS_SEL0 = PERIOD_MS_SEL0 * LRC_FREQ_KHZ;
  localparam int TICKS_SEL1 = PERIOD_MS_SEL1 * LRC_FREQ_KHZ;
  localparam int TICKS_SEL2 = PERIOD_MS_SEL2 * LRC_FREQ_KHZ;
  localparam int TICKS_SEL3 = PERIOD_MS_SEL3 * LRC_FREQ_KHZ;

  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_HALT = 2'b01,
    ST_SETTLE = 2'b11
  } halt_state_t;
endpackage

// ==== logic/halt_wakeup_rtc_reset.sv ====
// halt control with speaker, pin and periodic-timer wake-up, reset gathering
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
module halt_wakeup_rtc_reset
  import wake_pkg::*;
#(
  parameter int unsigned PERIOD_TICKS_SEL0 = TICKS_SEL0,
  parameter int unsigned PERIOD_TICKS_SEL1 = TICKS_SEL1,
  parameter int unsigned PERIOD_TICKS_SEL2 = TICKS_SEL2,
  parameter int unsigned PERIOD_TICKS_SEL3 = TICKS_SEL3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [wake_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [wake_pkg::DATA_W-1:0] bus_wdata,
  input wire logic bus_write,
  input wire logic bus_read,
  output logic [wake_pkg::DATA_W-1:0] bus_rdata,
  input wire logic halt_enter,
  input wire logic lrc_clk,
  input wire logic wake_compare_above,
  input wire logic pwm_positive_drive,
  input wire logic pwm_negative_drive,
  input wire logic [3:0] port_a_pins,
  input wire logic [3:0] port_b_pins,
  input wire logic [3:0] port_d_pins,
  input wire logic [3:0] port_e_pins,
  input wire logic port_c_fourth_pin,
  input wire logic port_a_fourth_drive,
  input wire logic port_a_fourth_drive_en,
  input wire logic power_on_detect,
  input wire logic low_voltage_reset,
  input wire logic watchdog_overflow,
  output logic audio_out_positive,
  output logic audio_out_positive_oe,
  output logic audio_out_negative,
  output logic audio_out_negative_oe,
  output logic port_a_fourth_pin_out,
  output logic port_a_fourth_pin_oe,
  output logic system_reset,
  output logic halted,
  output logic osc_run,
  output logic pc_hold,
  output logic vector_load,
  output logic [wake_pkg::VEC_W-1:0] vector_addr
);
  import wake_pkg::*;

  halt_state_t state_reg;
  halt_state_t state_next;
  logic [3:0] speaker_reg;
  logic [3:0] timer_reg;
  logic [3:0] clear_key_reg;
  logic [3:0] wake_en_a_reg;
  logic [3:0] wake_en_b_reg;
  logic [3:0] wake_en_d_reg;
  logic [3:0] wake_en_e_reg;
  logic [3:0] options_reg;
  logic [15:0] pins_prev_reg;
  logic lrc_prev_reg;
  logic [CNT_W-1:0] count_reg;
  logic [SETTLE_W-1:0] settle_reg;
  logic [DATA_W-1:0] rdata_reg;

  logic wr_speaker;
  logic wr_timer;
  logic wr_key;
  logic external_reset_n;
  logic reset_req;
  logic [15:0] pins_now;
  logic [15:0] pins_edge;
  logic [15:0] pins_enabled;
  logic pin_wake;
  logic speaker_armed;
  logic speaker_wake;
  logic lrc_tick;
  logic [CNT_W-1:0] period_last;
  logic overflow;
  logic timer_wake;
  logic wake_any;
  logic settle_done;
  logic halt_next;

  assign wr_speaker = bus_write && (bus_addr == ADDR_SPEAKER_WAKE);
  assign wr_timer = bus_write && (bus_addr == ADDR_TIMER_CTRL);
  assign wr_key = bus_write && (bus_addr == ADDR_CLEAR_KEY);

  // reset gathering
  assign external_reset_n = options_reg[OPT_RESET_PC_BIT] ?
                            port_c_fourth_pin : port_b_pins[3];
  assign reset_req = power_on_detect || low_voltage_reset ||
                     !external_reset_n || watchdog_overflow;

  // pin wake: pins are taken as already synchronous to clk
  assign pins_now = {port_e_pins, port_d_pins, port_b_pins, port_a_pins};
  assign pins_enabled = {wake_en_e_reg, wake_en_d_reg,
                         wake_en_b_reg, wake_en_a_reg};
  assign pins_edge = (pins_now & ~pins_prev_reg) |
                     ({16{options_reg[OPT_DOUBLE_EDGE_BIT]}} &
                      ~pins_now & pins_prev_reg);
  assign pin_wake = |(pins_edge & pins_enabled);

  // speaker path is only live inside halt
  assign speaker_armed = speaker_reg[SPK_EN_BIT] &&
                         (state_reg == ST_HALT);
  assign speaker_wake = speaker_armed && wake_compare_above;

  // periodic timer, stepped on rising edges of the low-rate oscillator
  assign lrc_tick = lrc_clk && !lrc_prev_reg;
  always_comb begin
    unique case (timer_reg[TMR_SEL_HI:TMR_SEL_LO])
      2'b00: period_last = CNT_W'(PERIOD_TICKS_SEL0 - 1);
      2'b01: period_last = CNT_W'(PERIOD_TICKS_SEL1 - 1);
      2'b10: period_last = CNT_W'(PERIOD_TICKS_SEL2 - 1);
      2'b11: period_last = CNT_W'(PERIOD_TICKS_SEL3 - 1);
    endcase
  end
  assign overflow = timer_reg[TMR_EN_BIT] && lrc_tick &&
                    !(wr_key && bus_wdata == CLEAR_KEY_VALUE) &&
                    (count_reg >= period_last);
  assign timer_wake = overflow && (state_reg == ST_HALT);

  assign wake_any = pin_wake || speaker_wake || timer_wake;
  assign settle_done = (settle_reg == SETTLE_W'(STABLE_CYCLES - 1));

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_NORMAL: begin
        if (halt_enter && !reset_req) begin
          state_next = ST_HALT;
        end
      end
      ST_HALT: begin
        if (reset_req || wake_any) begin
          state_next = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (settle_done) begin
          state_next = ST_NORMAL;
        end
      end
      default: state_next = ST_NORMAL;
    endcase
  end
  assign halt_next = (state_next == ST_HALT);

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_NORMAL;
    end else begin
      state_reg <= state_next;
    end
  end

  // stable-clock wait after any exit from halt
  always_ff @(posedge clk) begin
    if (rst || state_reg != ST_SETTLE) begin
      settle_reg <= '0;
    end else begin
      settle_reg <= settle_reg + SETTLE_W'(1);
    end
  end

  // core-facing halt outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      halted <= 1'b0;
      osc_run <= 1'b1;
      pc_hold <= 1'b0;
      vector_load <= 1'b0;
      vector_addr <= RESET_VECTOR;
    end else begin
      halted <= halt_next;
      // 8.192mhz from the 32mhz rc is stopped in halt only
      osc_run <= !halt_next;
      pc_hold <= (state_next != ST_NORMAL);
      vector_load <= (state_reg == ST_HALT) && (state_next == ST_SETTLE);
      if (state_reg == ST_NORMAL && halt_next) begin
        vector_addr <= WAKE_VECTOR;
      end else if (state_reg == ST_HALT && reset_req) begin
        vector_addr <= RESET_VECTOR;
      end else if (state_reg == ST_HALT && wake_any) begin
        vector_addr <= WAKE_VECTOR;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      system_reset <= 1'b0;
    end else begin
      system_reset <= reset_req;
    end
  end

  // edge history is not reset: a pin idling high must not look like a rise
  always_ff @(posedge clk) begin
    pins_prev_reg <= pins_now;
    lrc_prev_reg <= lrc_clk;
  end

  // counter holds its value while disabled and runs in every mode
  always_ff @(posedge clk) begin
    if (rst || wr_key && bus_wdata == CLEAR_KEY_VALUE) begin
      count_reg <= '0;
    end else if (timer_reg[TMR_EN_BIT] && lrc_tick) begin
      if (overflow) begin
        count_reg <= '0;
      end else begin
        count_reg <= count_reg + CNT_W'(1);
      end
    end
  end

  // speaker control: flag set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      speaker_reg <= REG_RESET;
    end else begin
      if (wr_speaker) begin
        speaker_reg[SPK_SEL_HI:SPK_EN_BIT] <= bus_wdata[SPK_SEL_HI:0];
      end
      if (speaker_wake) begin
        speaker_reg[SPK_FLAG_BIT] <= 1'b1;
      end else if (wr_speaker && !bus_wdata[SPK_FLAG_BIT]) begin
        speaker_reg[SPK_FLAG_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      timer_reg <= REG_RESET;
    end else begin
      if (wr_timer) begin
        timer_reg[TMR_EN_BIT:TMR_SEL_LO] <= bus_wdata[TMR_EN_BIT:0];
      end
      if (overflow) begin
        timer_reg[TMR_FLAG_BIT] <= 1'b1;
      end else if (wr_timer && !bus_wdata[TMR_FLAG_BIT]) begin
        timer_reg[TMR_FLAG_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clear_key_reg <= REG_RESET;
      wake_en_a_reg <= REG_RESET;
      wake_en_b_reg <= REG_RESET;
      wake_en_d_reg <= REG_RESET;
      wake_en_e_reg <= REG_RESET;
      options_reg <= REG_RESET;
    end else if (bus_write) begin
      unique case (bus_addr)
        ADDR_CLEAR_KEY: clear_key_reg <= bus_wdata;
        ADDR_WAKE_EN_A: wake_en_a_reg <= bus_wdata;
        ADDR_WAKE_EN_B: wake_en_b_reg <= bus_wdata;
        ADDR_WAKE_EN_D: wake_en_d_reg <= bus_wdata;
        ADDR_WAKE_EN_E: wake_en_e_reg <= bus_wdata;
        ADDR_OPTIONS: options_reg <= {1'b0, bus_wdata[2:0]};
        default: ;
      endcase
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst || !bus_read) begin
      rdata_reg <= '0;
    end else begin
      unique case (bus_addr)
        ADDR_SPEAKER_WAKE: rdata_reg <= speaker_reg;
        ADDR_TIMER_CTRL: rdata_reg <= timer_reg;
        ADDR_CLEAR_KEY: rdata_reg <= clear_key_reg;
        ADDR_WAKE_EN_A: rdata_reg <= wake_en_a_reg;
        ADDR_WAKE_EN_B: rdata_reg <= wake_en_b_reg;
        ADDR_WAKE_EN_D: rdata_reg <= wake_en_d_reg;
        ADDR_WAKE_EN_E: rdata_reg <= wake_en_e_reg;
        ADDR_OPTIONS: rdata_reg <= options_reg;
        ADDR_HALT_STATUS: rdata_reg <= {1'b0, speaker_armed,
                                        state_reg != ST_NORMAL,
                                        state_reg == ST_HALT};
        default: rdata_reg <= '0;
      endcase
    end
  end
  assign bus_rdata = rdata_reg;

  // audio pins: grounded while listening, released in plain halt
  always_ff @(posedge clk) begin
    if (rst) begin
      audio_out_positive <= 1'b0;
      audio_out_positive_oe <= 1'b1;
      audio_out_negative <= 1'b0;
      audio_out_negative_oe <= 1'b1;
    end else if (halt_next && speaker_reg[SPK_EN_BIT]) begin
      audio_out_positive <= 1'b0;
      audio_out_positive_oe <= 1'b1;
      audio_out_negative <= 1'b0;
      audio_out_negative_oe <= 1'b1;
    end else if (halt_next) begin
      audio_out_positive <= 1'b0;
      audio_out_positive_oe <= 1'b0;
      audio_out_negative <= 1'b0;
      audio_out_negative_oe <= 1'b0;
    end else begin
      audio_out_positive <= pwm_positive_drive;
      audio_out_positive_oe <= 1'b1;
      audio_out_negative <= pwm_negative_drive;
      audio_out_negative_oe <= 1'b1;
    end
  end

  // keeps an ir led on this pin from being left lit through halt
  always_ff @(posedge clk) begin
    if (rst) begin
      port_a_fourth_pin_out <= 1'b0;
      port_a_fourth_pin_oe <= 1'b0;
    end else if (halt_next && options_reg[OPT_CARRIER_BIT]) begin
      port_a_fourth_pin_out <= 1'b0;
      port_a_fourth_pin_oe <= 1'b1;
    end else begin
      port_a_fourth_pin_out <= port_a_fourth_drive;
      port_a_fourth_pin_oe <= port_a_fourth_drive_en;
    end
  end
endmodule

// ==== bench/halt_wakeup_rtc_reset_chk.sv ====
// port assertions for the halt, wake and reset block
`timescale 1ns/1ns
module halt_chk
  import wake_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pwm_positive_drive,
  input wire logic power_on_detect,
  input wire logic low_voltage_reset,
  input wire logic watchdog_overflow,
  input wire logic audio_out_positive,
  input wire logic audio_out_positive_oe,
  input wire logic audio_out_negative,
  input wire logic audio_out_negative_oe,
  input wire logic system_reset,
  input wire logic halted,
  input wire logic osc_run,
  input wire logic pc_hold,
  input wire logic vector_load,
  input wire logic [wake_pkg::VEC_W-1:0] vector_addr
);
  logic [6:0] settle_reg;
  logic src;
  assign src = power_on_detect | low_voltage_reset | watchdog_overflow;
  // counts settle cycles so the 64-cycle wait is checked exactly
  always_ff @(posedge clk) begin
    if (rst || !pc_hold) begin
      settle_reg <= 7'h00;
    end else if (!halted) begin
      settle_reg <= settle_reg + 7'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_leave;
    vector_load ##1 !vector_load;
  endsequence
  AST_ENTRY: assert property (
    $rose(halted) |-> pc_hold && !osc_run && vector_addr == 12'h004)
    else $error("halt entry outputs wrong");
  AST_OSC: assert property (osc_run != halted)
    else $error("oscillator state disagrees with halt");
  AST_LEAVE: assert property ($fell(halted) |-> s_leave)
    else $error("vector load not a single pulse on leaving halt");
  AST_SETTLE: assert property ($fell(pc_hold) |-> settle_reg == 7'h40)
    else $error("settle length not 64 cycles");
  AST_SPK_GND: assert property (
    halted && $past(halted) && audio_out_positive_oe |->
    !audio_out_positive && !audio_out_negative && audio_out_negative_oe)
    else $error("audio pins not held at ground");
  AST_PASS: assert property (
    !halted && !pc_hold && !$past(rst) && !$past(halted) &&
    !$past(pc_hold, 2) |->
    audio_out_positive == $past(pwm_positive_drive) && audio_out_positive_oe)
    else $error("audio not passed in normal mode");
  AST_SYS_RST: assert property (src |=> system_reset)
    else $error("reset source did not raise system reset");
  AST_RST_HALT: assert property (
    halted && src |=> !halted && vector_load && vector_addr == 12'h000)
    else $error("reset in halt did not return to normal");
endmodule
bind halt_wakeup_rtc_reset halt_chk i_halt_chk (
  .clk(clk),
  .rst(rst),
  .pwm_positive_drive(pwm_positive_drive),
  .power_on_detect(power_on_detect),
  .low_voltage_reset(low_voltage_reset),
  .watchdog_overflow(watchdog_overflow),
  .audio_out_positive(audio_out_positive),
  .audio_out_positive_oe(audio_out_positive_oe),
  .audio_out_negative(audio_out_negative),
  .audio_out_negative_oe(audio_out_negative_oe),
  .system_reset(system_reset),
  .halted(halted),
  .osc_run(osc_run),
  .pc_hold(pc_hold),
  .vector_load(vector_load),
  .vector_addr(vector_addr)
);

// ==== bench/tb_top.sv ====
// self-checking bench for the halt, wake and reset block
`timescale 1ns/1ns
module tb_top;
  import wake_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] bus_addr = '0;
  logic [DATA_W-1:0] bus_wdata = '0;
  logic bus_write = 1'b0, bus_read = 1'b0, halt_enter = 1'b0, lrc_clk = 1'b0;
  logic wake_compare_above = 1'b0, pwm_positive_drive = 1'b0;
  logic pwm_negative_drive = 1'b0, port_c_fourth_pin = 1'b1;
  logic [3:0] port_a_pins = '0, port_b_pins = 4'h8;
  logic [3:0] port_d_pins = '0, port_e_pins = '0;
  logic port_a_fourth_drive = 1'b0, port_a_fourth_drive_en = 1'b0;
  logic power_on_detect = 1'b0, low_voltage_reset = 1'b0;
  logic watchdog_overflow = 1'b0;
  logic [DATA_W-1:0] bus_rdata;
  logic audio_out_positive, audio_out_positive_oe, audio_out_negative;
  logic audio_out_negative_oe, port_a_fourth_pin_out, port_a_fourth_pin_oe;
  logic system_reset, halted, osc_run, pc_hold, vector_load;
  logic [VEC_W-1:0] vector_addr;
  logic [6:0] lrc_cnt = '0;
  int miscompares = 0, samples_checked = 0;
  // small periods keep the run short: 4, 8, 12 and 16 ticks
  halt_wakeup_rtc_reset #(.PERIOD_TICKS_SEL0(4), .PERIOD_TICKS_SEL1(8),
    .PERIOD_TICKS_SEL2(12), .PERIOD_TICKS_SEL3(16)) i_halt_wakeup_rtc_reset (.*);
  initial forever #50 clk = ~clk;
  // 100 clk cycles per low-rate period gives 100 khz
  always @(posedge clk) begin
    lrc_cnt <= (lrc_cnt == 7'h31) ? 7'h00 : lrc_cnt + 7'h01;
    if (lrc_cnt == 7'h31) lrc_clk <= ~lrc_clk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(string n, logic [11:0] s, logic [11:0] e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // outputs are sampled 1ns after the edge, once they have settled
  task automatic cyc(int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic wr(logic [7:0] a, logic [3:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_write <= 1'b1;
    cyc(1);
    bus_write <= 1'b0;
    // idle cycle so no strobe is driven twice in one time step
    cyc(1);
  endtask
  task automatic rdc(string n, logic [7:0] a, logic [3:0] e);
    bus_addr <= a;
    bus_read <= 1'b1;
    cyc(1);
    bus_read <= 1'b0;
    check(n, bus_rdata, e);
    cyc(1);
  endtask
  task automatic ticks(int n);
    repeat (n) @(posedge lrc_clk);
    cyc(1);
  endtask
  task automatic halt();
    halt_enter <= 1'b1;
    cyc(1);
    halt_enter <= 1'b0;
    check("halted", halted, 1'b1);
    check("halt_vec", vector_addr, WAKE_VECTOR);
  endtask
  task automatic wake(logic [11:0] v, int lim);
    int i;
    for (i = 0; i < lim && halted !== 1'b0; i++) cyc(1);
    if (halted !== 1'b0) begin
      miscompares++;
      report_and_stop();
    end
    check("vec_load", vector_load, 1'b1);
    check("vec_addr", vector_addr, v);
    for (i = 0; i < 100 && pc_hold === 1'b1; i++) cyc(1);
    check("settle", 12'(i), 12'h040);
  endtask
  task automatic t_regs();
    rdc("spk_rst", ADDR_SPEAKER_WAKE, REG_RESET);
    rdc("tmr_rst", ADDR_TIMER_CTRL, REG_RESET);
    wr(8'h30, 4'hF);
    rdc("unmapped", 8'h30, 4'h0);
  endtask
  task automatic t_timer();
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_TIMER_CTRL, {2'b01, 2'(s)});
      wr(ADDR_CLEAR_KEY, CLEAR_KEY_VALUE);
      ticks(4 * s + 2);
      rdc("early", ADDR_TIMER_CTRL, {2'b01, 2'(s)});
      ticks(3);
      rdc("period", ADDR_TIMER_CTRL, {2'b11, 2'(s)});
    end
    wr(ADDR_TIMER_CTRL, 4'hF);
    ticks(2);
    rdc("sticky", ADDR_TIMER_CTRL, 4'hF);
    wr(ADDR_TIMER_CTRL, 4'h4);
    ticks(3);
    wr(ADDR_TIMER_CTRL, 4'h4);
    wr(ADDR_CLEAR_KEY, CLEAR_KEY_VALUE);
    ticks(2);
    rdc("cleared", ADDR_TIMER_CTRL, 4'h4);
    ticks(3);
    rdc("after_clr", ADDR_TIMER_CTRL, 4'hC);
    wr(ADDR_TIMER_CTRL, 4'h0);
    ticks(20);
    rdc("stopped", ADDR_TIMER_CTRL, 4'h0);
  endtask
  task automatic t_twake();
    wr(ADDR_TIMER_CTRL, 4'h4);
    halt();
    wake(WAKE_VECTOR, 1000);
    rdc("halt_flag", ADDR_TIMER_CTRL, 4'hC);
    wr(ADDR_TIMER_CTRL, 4'h0);
  endtask
  task automatic t_pin();
    wr(ADDR_WAKE_EN_B, 4'h1);
    port_b_pins <= 4'h9;
    cyc(3);
    halt();
    port_b_pins <= 4'h8;
    cyc(10);
    check("no_fall", halted, 1'b1);
    port_b_pins <= 4'h9;
    wake(WAKE_VECTOR, 10);
    wr(ADDR_OPTIONS, 4'h1);
    cyc(3);
    halt();
    port_b_pins <= 4'h8;
    wake(WAKE_VECTOR, 10);
    wr(ADDR_WAKE_EN_D, 4'h2);
    halt();
    port_d_pins <= 4'h2;
    wake(WAKE_VECTOR, 10);
  endtask
  task automatic t_spk();
    wr(ADDR_SPEAKER_WAKE, 4'h1);
    wr(ADDR_WAKE_EN_A, 4'h0);
    wr(ADDR_OPTIONS, 4'h2);
    pwm_positive_drive <= 1'b1;
    pwm_negative_drive <= 1'b1;
    port_a_fourth_drive <= 1'b1;
    port_a_fourth_drive_en <= 1'b1;
    cyc(2);
    check("pwm_pass", audio_out_positive, 1'b1);
    check("pwm_pass_n", audio_out_negative, 1'b1);
    check("pa4_norm", port_a_fourth_pin_out, 1'b1);
    // silence before halt is much shorter than in use, to keep the run short
    pwm_positive_drive <= 1'b0;
    pwm_negative_drive <= 1'b0;
    cyc(2);
    halt();
    pwm_positive_drive <= 1'b1;
    pwm_negative_drive <= 1'b1;
    cyc(3);
    check("no_wake", halted, 1'b1);
    check("spk_p", {audio_out_positive, audio_out_positive_oe}, 2'b01);
    check("spk_n", {audio_out_negative, audio_out_negative_oe}, 2'b01);
    check("pa4_halt", {port_a_fourth_pin_out, port_a_fourth_pin_oe}, 2'b01);
    wake_compare_above <= 1'b1;
    wake(WAKE_VECTOR, 10);
    wake_compare_above <= 1'b0;
    cyc(5);
    rdc("spk_flag", ADDR_SPEAKER_WAKE, 4'h9);
    wr(ADDR_SPEAKER_WAKE, 4'h1);
    rdc("spk_clr", ADDR_SPEAKER_WAKE, 4'h1);
    wr(ADDR_OPTIONS, 4'h0);
    wr(ADDR_SPEAKER_WAKE, 4'h0);
    halt();
    cyc(2);
    check("pa4_io", port_a_fourth_pin_out, 1'b1);
    port_b_pins <= 4'h9;
    wake(WAKE_VECTOR, 10);
  endtask
  task automatic t_reset();
    halt();
    watchdog_overflow <= 1'b1;
    cyc(1);
    watchdog_overflow <= 1'b0;
    check("wdg_rst", system_reset, 1'b1);
    wake(RESET_VECTOR, 3);
    for (int j = 0; j < 3; j++) begin
      {power_on_detect, low_voltage_reset, watchdog_overflow} <= 3'b001 << j;
      cyc(1);
      check("src_on", system_reset, 1'b1);
      {power_on_detect, low_voltage_reset, watchdog_overflow} <= 3'b000;
      cyc(1);
      check("src_off", system_reset, 1'b0);
    end
    port_b_pins <= 4'h1;
    cyc(1);
    check("pb_rst", system_reset, 1'b1);
    port_b_pins <= 4'h9;
    wr(ADDR_OPTIONS, 4'h4);
    port_b_pins <= 4'h1;
    cyc(2);
    check("pb_unsel", system_reset, 1'b0);
    port_c_fourth_pin <= 1'b0;
    cyc(1);
    check("pc_rst", system_reset, 1'b1);
    port_c_fourth_pin <= 1'b1;
    port_b_pins <= 4'h9;
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    cyc(1);
    rdc("opt_rst", ADDR_OPTIONS, 4'h0);
  endtask
  initial begin
    cyc(10);
    rst <= 1'b0;
    cyc(1);
    t_regs();
    t_timer();
    t_twake();
    t_pin();
    t_spk();
    t_reset();
    report_and_stop();
  end
endmodule
